// file: logic/osc_ctrl_pkg.sv
// Package with register map, field layouts and timing constants for oscillator source control
package osc_ctrl_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_CAL      = 4'h0;
	localparam logic [3:0] ADDR_EXT_CTRL = 4'h1;
	localparam logic [3:0] ADDR_CLK_SEL  = 4'h2;
	localparam logic [3:0] ADDR_STATUS   = 4'h3;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
	localparam logic [3:0] ADDR_INT_CTRL = 4'h6;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int SSE_BIT       = 7;
	localparam int EXT_VALID_BIT = 7;
	localparam int EXT_DIV2_BIT  = 3;
	localparam logic [6:0] CAL_TRIM_DEFAULT = 7'h40;
	localparam logic [7:0] EXT_CTRL_RESET   = 8'h00;

	// ****************************************
	// Spread spectrum timing
	// ****************************************
	localparam int SS_PERIOD    = 384;
	localparam int SS_STEPS     = 6;
	localparam int SS_STEP_LEN  = SS_PERIOD / (2 * SS_STEPS);
	localparam logic [6:0] SS_MAX_DEPTH = 7'h06;

	// External oscillator modes
	typedef enum logic [2:0]
	{
		EXT_OFF     = 3'h0,
		EXT_CMOS    = 3'h2,
		EXT_CAP     = 3'h4,
		EXT_RC      = 3'h5,
		EXT_CRYSTAL = 3'h6
	} ext_mode_type;

	// System clock sources
	typedef enum logic [2:0]
	{
		SRC_PRECISION = 3'h0,
		SRC_EXTERNAL  = 3'h1,
		SRC_LP_DIV8   = 3'h2,
		SRC_RTC       = 3'h3,
		SRC_LOW_POWER = 3'h4
	} clk_src_type;

	// Bus request carrier
	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_type;
endpackage : osc_ctrl_pkg

// file: logic/oscillator_source_control.sv
// Clock source control: precision trim and dither, low power enable, external oscillator control
//
// Summary of operation
// - Spread enable dithers precision oscillator triangularly
// - Dither period is 384 oscillator cycles
// - Dither only lowers frequency, six steps
// - Calibration resets to factory trim value
// - Reset selects low power oscillator
// - Low power oscillator runs only when selected
// - External clock feeds system and peripherals
// - External circuit has four modes
// - Crystal mode optional divide by two
// - Valid flag rises once oscillation stable
// - CMOS mode valid always reads zero
// - Spread enable is calibration bit seven
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_control
#(
	parameter int STABLE_COUNT = 1024
)
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire osc_ctrl_pkg::bus_req_type bus_i,
	input  wire logic                      ext_osc_clk_i,
	input  wire logic                      ext_osc_running_i,
	output logic [7:0]                     rdata_o,
	output logic [6:0]                     precision_trim_o,
	output logic                           precision_osc_en_o,
	output logic                           low_power_osc_en_o,
	output logic [2:0]                     sys_clk_sel_o,
	output logic [2:0]                     ext_osc_mode_o,
	output logic [2:0]                     external_osc_freq_control_o,
	output logic                           ext_clk_o,
	output logic                           periph_ext_clk_o,
	output logic                           crystal_pin_a_analog_o,
	output logic                           crystal_pin_b_analog_o,
	output logic                           irq_o
);
	// Elaboration check
	if (STABLE_COUNT < 2 || STABLE_COUNT > 65535)
	begin : g_bad_param
		$error("STABLE_COUNT out of range");
	end

	// ****************************************
	// Register state
	// ****************************************
	logic                    spread_spectrum_enable;
	logic [6:0]              precision_osc_calibration;
	logic [7:0]              external_osc_control;
	logic [2:0]              clk_sel;
	logic                    precision_en;
	logic [1:0]              irq_status;
	logic [1:0]              irq_mask;
	logic                    external_osc_valid;
	logic [15:0]             stable_cnt;
	logic                    valid_q;
	logic                    div2_q;
	logic                    ext_prev;
	logic [8:0]              ss_cnt;
	logic [6:0]              ss_depth;
	logic [7:0]              next_rdata;

	// Helper: mode of the external circuit
	function automatic logic [2:0] mode_of(input logic [7:0] ctrl);
		mode_of = ctrl[6:4];
	endfunction : mode_of

	// Helper: mode counts as a stabilising oscillator
	function automatic logic needs_stab(input logic [2:0] m);
		needs_stab = (m == osc_ctrl_pkg::EXT_CRYSTAL) || (m == osc_ctrl_pkg::EXT_RC)
			|| (m == osc_ctrl_pkg::EXT_CAP);
	endfunction : needs_stab

	// ****************************************
	// Register writes
	// ****************************************
	// Calibration register with spread enable in bit seven
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			spread_spectrum_enable    <= 1'b0;
			precision_osc_calibration <= osc_ctrl_pkg::CAL_TRIM_DEFAULT;
		end
		else if (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_CAL)
		begin
			spread_spectrum_enable    <= bus_i.wdata[osc_ctrl_pkg::SSE_BIT];
			precision_osc_calibration <= bus_i.wdata[6:0];
		end
	end

	// External oscillator control: mode, divide by two, band code
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			external_osc_control <= osc_ctrl_pkg::EXT_CTRL_RESET;
		else if (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_EXT_CTRL)
			external_osc_control <= {1'b0, bus_i.wdata[6:0]};
	end

	// Clock select and precision oscillator enable
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			clk_sel      <= osc_ctrl_pkg::SRC_LOW_POWER;
			precision_en <= 1'b0;
		end
		else
		begin
			if (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_CLK_SEL)
				clk_sel <= bus_i.wdata[2:0];
			if (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_INT_CTRL)
				precision_en <= bus_i.wdata[0];
		end
	end

	// ****************************************
	// External oscillator valid detector
	// ****************************************
	// Counts consecutive cycles of running oscillation; mode change restarts
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			stable_cnt <= 16'h0000;
			valid_q    <= 1'b0;
		end
		else if (!needs_stab(mode_of(external_osc_control)) || !ext_osc_running_i
			|| (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_EXT_CTRL))
		begin
			stable_cnt <= 16'h0000;
			valid_q    <= 1'b0;
		end
		else if (stable_cnt == 16'(STABLE_COUNT - 1))
			valid_q <= 1'b1;
		else
			stable_cnt <= stable_cnt + 16'h0001;
	end

	assign external_osc_valid = valid_q;

	// ****************************************
	// External clock path
	// ****************************************
	// Divide by two toggles on each rising source edge for an even duty cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			div2_q <= 1'b0;
		else if (ext_osc_clk_i && !ext_prev)
			div2_q <= ~div2_q;
	end

	// Previous source level; resets to the idle low level so no false edge follows reset
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ext_prev <= 1'b0;
		else
			ext_prev <= ext_osc_clk_i;
	end

	// Selected external clock to system and peripherals
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ext_clk_o        <= 1'b0;
			periph_ext_clk_o <= 1'b0;
		end
		else
		begin
			ext_clk_o        <= external_osc_control[osc_ctrl_pkg::EXT_DIV2_BIT] ? div2_q : ext_osc_clk_i;
			periph_ext_clk_o <= external_osc_control[osc_ctrl_pkg::EXT_DIV2_BIT] ? div2_q : ext_osc_clk_i;
		end
	end

	// ****************************************
	// Spread spectrum triangle
	// ****************************************
	// Period counter and stepped depth, rising then falling, never above nominal
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !spread_spectrum_enable)
		begin
			ss_cnt   <= 9'h000;
			ss_depth <= 7'h00;
		end
		else
		begin
			ss_cnt <= (ss_cnt == 9'(osc_ctrl_pkg::SS_PERIOD - 1)) ? 9'h000 : ss_cnt + 9'h001;
			if (ss_cnt % 9'(osc_ctrl_pkg::SS_STEP_LEN) == 9'h000)
			begin
				if (ss_cnt <= 9'(osc_ctrl_pkg::SS_PERIOD / 2))
					ss_depth <= (ss_cnt == 9'h000) ? 7'h00 : ss_depth + 7'h01;
				else
					ss_depth <= ss_depth - 7'h01;
			end
		end
	end

	// Trim output lowered by dither depth; saturates at zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			precision_trim_o <= osc_ctrl_pkg::CAL_TRIM_DEFAULT;
		else if (ss_depth > osc_ctrl_pkg::SS_MAX_DEPTH)
			precision_trim_o <= precision_osc_calibration;
		else if (precision_osc_calibration > ss_depth)
			precision_trim_o <= precision_osc_calibration - ss_depth;
		else
			precision_trim_o <= 7'h00;
	end

	// ****************************************
	// Oscillator enables and pin setup
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			low_power_osc_en_o          <= 1'b1;
			precision_osc_en_o          <= 1'b0;
			sys_clk_sel_o               <= osc_ctrl_pkg::SRC_LOW_POWER;
			ext_osc_mode_o              <= osc_ctrl_pkg::EXT_OFF;
			external_osc_freq_control_o <= 3'h0;
			crystal_pin_a_analog_o      <= 1'b0;
			crystal_pin_b_analog_o      <= 1'b0;
		end
		else
		begin
			low_power_osc_en_o <= (clk_sel == osc_ctrl_pkg::SRC_LOW_POWER)
				|| (clk_sel == osc_ctrl_pkg::SRC_LP_DIV8);
			precision_osc_en_o          <= precision_en || (clk_sel == osc_ctrl_pkg::SRC_PRECISION);
			sys_clk_sel_o               <= clk_sel;
			ext_osc_mode_o              <= mode_of(external_osc_control);
			external_osc_freq_control_o <= external_osc_control[2:0];
			crystal_pin_a_analog_o      <= mode_of(external_osc_control) == osc_ctrl_pkg::EXT_CRYSTAL;
			crystal_pin_b_analog_o      <= needs_stab(mode_of(external_osc_control));
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	// Next valid value, from the detector's own terms
	function automatic logic external_osc_valid_next();
		external_osc_valid_next = needs_stab(mode_of(external_osc_control)) && ext_osc_running_i
			&& !(bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_EXT_CTRL)
			&& (valid_q || stable_cnt == 16'(STABLE_COUNT - 1));
	endfunction : external_osc_valid_next

	// Bit 0 valid rose, bit 1 valid lost; set wins over clear
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_status <= 2'h0;
			irq_mask   <= 2'h0;
		end
		else
		begin
			if (bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_IRQ_MASK)
				irq_mask <= bus_i.wdata[1:0];
			irq_status <= (irq_status & ~((bus_i.wr && bus_i.addr == osc_ctrl_pkg::ADDR_IRQ_STAT)
				? bus_i.wdata[1:0] : 2'h0))
				| {valid_q & ~external_osc_valid_next(), 1'b0}
				| {1'b0, ~valid_q & external_osc_valid_next()};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(irq_status & irq_mask);
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb
	begin
		next_rdata = 8'h00;
		if (bus_i.addr == osc_ctrl_pkg::ADDR_CAL)
			next_rdata = {spread_spectrum_enable, precision_osc_calibration};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_EXT_CTRL)
			next_rdata = {external_osc_valid, external_osc_control[6:0]};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_CLK_SEL)
			next_rdata = {5'h00, clk_sel};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_STATUS)
			next_rdata = {6'h00, low_power_osc_en_o, precision_osc_en_o};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_IRQ_STAT)
			next_rdata = {6'h00, irq_status};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_IRQ_MASK)
			next_rdata = {6'h00, irq_mask};
		else if (bus_i.addr == osc_ctrl_pkg::ADDR_INT_CTRL)
			next_rdata = {7'h00, precision_en};
	end

	// Read data registered one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= bus_i.rd ? next_rdata : 8'h00;
	end
endmodule : oscillator_source_control
`default_nettype wire

// file: dv/ext_osc_model.sv
// External oscillator model: crystal, RC, capacitor or CMOS clock at the pins
`timescale 1ns/100ps
`default_nettype none
module ext_osc_model
#(
	parameter int HALF = 4
)
(
	input  wire logic       clk_i,
	input  wire logic       present_i,
	input  wire logic [2:0] mode_i,
	output logic            running_o,
	output logic            osc_o
);
	int cnt = 0;

	// Detector sees oscillation only in the analog modes
	assign running_o = present_i && (mode_i inside {3'h4, 3'h5, 3'h6});

	initial osc_o = 1'b0;

	// Oscillation stands still at zero while absent or switched off
	always @(posedge clk_i)
	begin
		if (!present_i || mode_i == 3'h0)
		begin
			cnt = 0;
			osc_o <= 1'b0;
		end
		else if (cnt == HALF - 1)
		begin
			cnt = 0;
			osc_o <= !osc_o;
		end
		else
			cnt++;
	end
endmodule : ext_osc_model
`default_nettype wire

// file: dv/oscillator_source_control_chk.sv
// Checker for the clock source control ports
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_control_chk
#(
	parameter int STABLE_COUNT = 1024
)
(
	input wire logic                      clk_i,
	input wire logic                      rst_n_i,
	input wire osc_ctrl_pkg::bus_req_type bus_i,
	input wire logic                      ext_osc_clk_i,
	input wire logic                      ext_osc_running_i,
	input wire logic [7:0]                rdata_o,
	input wire logic [6:0]                precision_trim_o,
	input wire logic                      precision_osc_en_o,
	input wire logic                      low_power_osc_en_o,
	input wire logic [2:0]                sys_clk_sel_o,
	input wire logic [2:0]                ext_osc_mode_o,
	input wire logic [2:0]                external_osc_freq_control_o,
	input wire logic                      ext_clk_o,
	input wire logic                      periph_ext_clk_o,
	input wire logic                      crystal_pin_a_analog_o,
	input wire logic                      crystal_pin_b_analog_o,
	input wire logic                      irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	rd_idle_a: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read answer");
	reset_src_a: assert property ($rose(rst_n_i) |-> sys_clk_sel_o == 3'h4 && low_power_osc_en_o)
		else $error("low power source not selected after reset");
	lp_follow_a: assert property (low_power_osc_en_o == (sys_clk_sel_o inside {3'h2, 3'h4}))
		else $error("low power enable does not follow selection");
	pin_b_a: assert property (crystal_pin_b_analog_o == (ext_osc_mode_o inside {3'h4, 3'h5, 3'h6}))
		else $error("pin b analog setting wrong for mode");
	pin_a_a: assert property (crystal_pin_a_analog_o == (ext_osc_mode_o == 3'h6))
		else $error("pin a analog setting wrong for mode");
	periph_clk_a: assert property (periph_ext_clk_o == ext_clk_o)
		else $error("peripheral clock differs from external clock");
	cmos_valid_a: assert property ($past(bus_i.rd) && $past(bus_i.addr) == 4'h1 && $past(ext_osc_mode_o) == 3'h2
		|-> !rdata_o[7])
		else $error("valid flag read as one in CMOS mode");
	trim_step_a: assert property (!$past(bus_i.wr) && !$past(bus_i.wr, 2) && !$past(bus_i.wr, 3)
		|-> 7'(precision_trim_o - $past(precision_trim_o)) inside {7'h00, 7'h01, 7'h7F})
		else $error("trim moved by more than one step");

	cover property (rdata_o[7]);
	cover property (precision_trim_o == 7'h3A);
	cover property (irq_o);
endmodule : oscillator_source_control_chk
`default_nettype wire

bind oscillator_source_control oscillator_source_control_chk #(.STABLE_COUNT(STABLE_COUNT)) chk_i
(
	.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .ext_osc_clk_i(ext_osc_clk_i),
	.ext_osc_running_i(ext_osc_running_i), .rdata_o(rdata_o), .precision_trim_o(precision_trim_o),
	.precision_osc_en_o(precision_osc_en_o), .low_power_osc_en_o(low_power_osc_en_o),
	.sys_clk_sel_o(sys_clk_sel_o), .ext_osc_mode_o(ext_osc_mode_o),
	.external_osc_freq_control_o(external_osc_freq_control_o), .ext_clk_o(ext_clk_o),
	.periph_ext_clk_o(periph_ext_clk_o), .crystal_pin_a_analog_o(crystal_pin_a_analog_o),
	.crystal_pin_b_analog_o(crystal_pin_b_analog_o), .irq_o(irq_o)
);

// file: dv/oscillator_source_control_tb.sv
// Testbench for clock source control
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_control_tb;
	localparam int SC = 8;
	logic                      clk_i = 1'b0;
	logic                      rst_n_i = 1'b0;
	logic                      present = 1'b0;
	osc_ctrl_pkg::bus_req_type bus_i = '0;
	logic                      osc, running, ext_clk, lp_en, irq;
	logic [7:0]                rdata;
	logic [6:0]                trim, lo, hi;
	logic [2:0]                sel, mode, band;
	logic [2:0]                modes [4] = '{3'h2, 3'h4, 3'h5, 3'h6};
	logic [2:0]                bands [4] = '{3'h1, 3'h2, 3'h0, 3'h7};
	int                        n_fail = 0;
	int                        samples_checked = 0;
	int                        cnt;

	// Clock
	always #4 clk_i = ~clk_i;

	ext_osc_model #(.HALF(4)) partner (.clk_i(clk_i), .present_i(present), .mode_i(mode),
		.running_o(running), .osc_o(osc));

	oscillator_source_control #(.STABLE_COUNT(SC)) DUT
	(
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .ext_osc_clk_i(osc), .ext_osc_running_i(running),
		.rdata_o(rdata), .precision_trim_o(trim), .precision_osc_en_o(), .low_power_osc_en_o(lp_en),
		.sys_clk_sel_o(sel), .ext_osc_mode_o(mode), .external_osc_freq_control_o(band), .ext_clk_o(ext_clk),
		.periph_ext_clk_o(), .crystal_pin_a_analog_o(), .crystal_pin_b_analog_o(), .irq_o(irq)
	);

	task automatic report_and_stop;
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus_i <= '0;
	endtask : wr

	task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus_i <= '0;
		#1 chk(n, e, rdata);
	endtask : rchk

	// Length of one high phase of the external clock, in system cycles
	task automatic hi_len(output int c);
		c = 0;
		do @(posedge clk_i); while (ext_clk !== 1'b0);
		do @(posedge clk_i); while (ext_clk !== 1'b1);
		do
		begin
			@(posedge clk_i);
			c++;
		end while (ext_clk === 1'b1);
	endtask : hi_len

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		report_and_stop();
	end

	// Test sequence
	initial
	begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk("cal", 4'h0, 8'h40);
		rchk("clk_sel", 4'h2, 8'h04);
		rchk("status", 4'h3, 8'h02);
		rchk("unmapped", 4'hF, 8'h00);
		wr(4'h2, 8'h00);
		rchk("status_prec", 4'h3, 8'h01);
		wr(4'h2, 8'h02);
		rchk("status_lp8", 4'h3, 8'h02);
		wr(4'h6, 8'h01);
		rchk("int_ctrl", 4'h6, 8'h01);
		rchk("status_both", 4'h3, 8'h03);
		present <= 1'b1;
		wr(4'h5, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h1, {1'b0, modes[i], 1'b0, bands[i]});
			rchk("ext_fresh", 4'h1, {1'b0, modes[i], 1'b0, bands[i]});
			repeat (SC + 4) @(posedge clk_i);
			rchk("ext_ok", 4'h1, {modes[i] != 3'h2, modes[i], 1'b0, bands[i]});
			chk("mode", {5'h00, modes[i]}, {5'h00, mode});
			chk("band", {5'h00, bands[i]}, {5'h00, band});
		end
		chk("irq_set", 8'h01, {7'h00, irq});
		rchk("irq_stat", 4'h4, 8'h03);
		rchk("irq_mask_rd", 4'h5, 8'h01);
		wr(4'h5, 8'h00);
		repeat (2) @(posedge clk_i);
		chk("irq_mask", 8'h00, {7'h00, irq});
		wr(4'h5, 8'h01);
		wr(4'h4, 8'h03);
		repeat (2) @(posedge clk_i);
		chk("irq_clr", 8'h00, {7'h00, irq});
		rchk("irq_stat_clr", 4'h4, 8'h00);
		hi_len(cnt);
		chk("hi_plain", 8'h04, 8'(cnt));
		wr(4'h1, 8'h6F);
		hi_len(cnt);
		hi_len(cnt);
		chk("hi_div2", 8'h08, 8'(cnt));
		repeat (SC + 4) @(posedge clk_i);
		rchk("valid", 4'h1, 8'hEF);
		wr(4'h2, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("sel_ext", 8'h01, {5'h00, sel});
		chk("lp_off", 8'h00, {7'h00, lp_en});
		wr(4'h0, 8'hC0);
		lo = 7'h7F;
		hi = 7'h00;
		cnt = 0;
		repeat (768)
		begin
			@(posedge clk_i);
			lo = (trim < lo) ? trim : lo;
			hi = (trim > hi) ? trim : hi;
			cnt += (trim === 7'h3A);
		end
		chk("dither_min", 8'h3A, {1'b0, lo});
		chk("dither_max", 8'h40, {1'b0, hi});
		chk("deepest_cycles", 8'h40, 8'(cnt));
		wr(4'h0, 8'h40);
		repeat (4) @(posedge clk_i);
		chk("trim_still", 8'h40, {1'b0, trim});
		report_and_stop();
	end
endmodule : oscillator_source_control_tb
`default_nettype wire
